// >>> restart_seq_pkg.sv
package restart_seq_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUCCESS_TIME_S = 1;
    localparam logic [15:0] SUCCESS_TICKS = 16'(SUCCESS_TIME_S * 1000);
    localparam int RESTART_WAIT_TIME_S10 = 10;
    localparam int MONITOR_TIME_S = 60;
    localparam logic [15:0] FREQ_MAX = 16'hffff;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MAGNET_OFS = 8'h04;
    localparam logic [7:0] RESTART_OFS = 8'h08;
    localparam logic [7:0] SEARCH_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    typedef struct packed {
        logic [7:0] rsv_hi;
        logic [7:0] start_attempt_limit;
        logic [2:0] rsv_mid;
        logic [4:0] auto_restart_mode;
        logic [2:0] rsv_lo;
        logic reluctance_motor;
        logic catch_spin_enable_source;
        logic [2:0] catch_spin_mode;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] deexcitation_lockout_time;
        logic [15:0] excitation_build_time;
    } magnet_t;

    typedef struct packed {
        logic [15:0] restart_monitor_time;
        logic [15:0] restart_wait_time;
    } restart_t;

    typedef struct packed {
        logic [15:0] search_rate_factor;
        logic [15:0] search_current_level;
    } search_t;

    localparam logic [31:0] CTRL_RST = 32'h0003_0000;
    localparam logic [31:0] MAGNET_RST = 32'h0000_0000;
    localparam logic [31:0] RESTART_RST = {16'(MONITOR_TIME_S * 1000), 16'(RESTART_WAIT_TIME_S10 * 100)};
    localparam logic [31:0] SEARCH_RST = 32'h0004_0080;

    localparam logic [2:0] SPIN_OFF = 3'h0;
    localparam logic [2:0] SPIN_BOTH = 3'h1;
    localparam logic [2:0] SPIN_SETPOINT = 3'h4;

    localparam logic [4:0] ARM_OFF = 5'h00;
    localparam logic [4:0] ARM_ACK = 5'h01;
    localparam logic [4:0] ARM_PF = 5'h04;
    localparam logic [4:0] ARM_FAULT = 5'h06;
    localparam logic [4:0] ARM_PF_MAN = 5'h0e;
    localparam logic [4:0] ARM_FAULT_MAN = 5'h10;
    localparam logic [4:0] ARM_ALL = 5'h1a;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_WAIT = 3'h1,
        ST_SEARCH = 3'h3,
        ST_EXCITE = 3'h2,
        ST_CHECK = 3'h6,
        ST_RUN = 3'h7,
        ST_DEEXC = 3'h5,
        ST_FAULT = 3'h4
    } state_t;

endpackage

// >>> ms_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
    parameter int TICK_CYCLES = restart_seq_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    output var logic tick
);
    logic [31:0] cnt_reg;
    wire cnt_end = (cnt_reg == 32'(TICK_CYCLES - 1));

    // Free running divider, one pulse per millisecond.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_end ? 32'h0 : cnt_reg + 32'h1;
            tick <= cnt_end;
        end
    end
endmodule // ms_tick_gen
`default_nettype wire

// >>> motor_restart_sequencer.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module motor_restart_sequencer #(
    parameter int TICK_CYCLES = restart_seq_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic [31:0] hrdata,
    output var logic hreadyout,
    output var logic hresp,
    input wire logic run_command,
    input wire logic catch_spin_enable_pin,
    input wire logic setpoint_dir,
    input wire logic motor_dir,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] magnetizing_current_ref,
    input wire logic fault_in,
    input wire logic undervoltage_fault,
    input wire logic manual_ack,
    input wire logic supply_lost_strap,
    output var logic motor_on,
    output var logic [15:0] search_current,
    output var logic [15:0] out_freq,
    output var logic search_dir,
    output var logic ramp_enable,
    output var logic magnetization_done_flag,
    output var logic fault_ack,
    output var logic start_success,
    output var logic restart_failed
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release and time base.
    logic [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    logic tick;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decoding.
    function automatic logic ack_allowed(input logic [4:0] m, input logic run);
        return (m == restart_seq_pkg::ARM_ACK) || (m == restart_seq_pkg::ARM_ALL) ||
               (((m == restart_seq_pkg::ARM_PF) || (m == restart_seq_pkg::ARM_FAULT)) && run);
    endfunction

    function automatic logic restart_allowed(input logic [4:0] m, input logic pf, input logic run);
        return run && ((m == restart_seq_pkg::ARM_FAULT) || (m == restart_seq_pkg::ARM_FAULT_MAN) ||
               (m == restart_seq_pkg::ARM_ALL) ||
               (((m == restart_seq_pkg::ARM_PF) || (m == restart_seq_pkg::ARM_PF_MAN)) && pf));
    endfunction

    function automatic logic counts_attempts(input logic [4:0] m);
        return (m == restart_seq_pkg::ARM_PF) || (m == restart_seq_pkg::ARM_FAULT) ||
               (m == restart_seq_pkg::ARM_PF_MAN) || (m == restart_seq_pkg::ARM_FAULT_MAN) ||
               (m == restart_seq_pkg::ARM_ALL);
    endfunction

    function automatic logic is_running(input restart_seq_pkg::state_t s);
        return (s == restart_seq_pkg::ST_SEARCH) || (s == restart_seq_pkg::ST_EXCITE) ||
               (s == restart_seq_pkg::ST_CHECK) || (s == restart_seq_pkg::ST_RUN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait writes, one wait state on reads.
    restart_seq_pkg::ctrl_t ctrl_reg;
    restart_seq_pkg::magnet_t magnet_reg;
    restart_seq_pkg::restart_t restart_reg;
    restart_seq_pkg::search_t search_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] status_word;
    restart_seq_pkg::state_t state_reg;
    restart_seq_pkg::state_t state_next;
    logic [7:0] attempts_reg;

    wire addr_take = hsel & htrans[1] & hready;
    wire wr_ctrl = wr_pend_reg & (addr_reg == restart_seq_pkg::CTRL_OFS);
    wire wr_magnet = wr_pend_reg & (addr_reg == restart_seq_pkg::MAGNET_OFS);
    wire wr_restart = wr_pend_reg & (addr_reg == restart_seq_pkg::RESTART_OFS);
    wire wr_search = wr_pend_reg & (addr_reg == restart_seq_pkg::SEARCH_OFS);
    wire [31:0] ctrl_rd = ctrl_reg & 32'h00ff_1f1f;
    wire [31:0] rd_mux =
        (addr_reg == restart_seq_pkg::CTRL_OFS) ? ctrl_rd :
        (addr_reg == restart_seq_pkg::MAGNET_OFS) ? magnet_reg :
        (addr_reg == restart_seq_pkg::RESTART_OFS) ? restart_reg :
        (addr_reg == restart_seq_pkg::SEARCH_OFS) ? search_reg :
        (addr_reg == restart_seq_pkg::STATUS_OFS) ? status_word : 32'h0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
        end else begin
            wr_pend_reg <= addr_take & hwrite;
            rd_pend_reg <= addr_take & ~hwrite;
            if (addr_take) addr_reg <= {haddr[7:2], 2'h0};
            hreadyout <= ~(addr_take & ~hwrite);
            hresp <= 1'b0;
            if (rd_pend_reg) hrdata <= rd_mux;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= restart_seq_pkg::CTRL_RST;
            magnet_reg <= restart_seq_pkg::MAGNET_RST;
            restart_reg <= restart_seq_pkg::RESTART_RST;
            search_reg <= restart_seq_pkg::SEARCH_RST;
        end else begin
            if (wr_ctrl) ctrl_reg <= hwdata & 32'h00ff_1f1f;
            if (wr_magnet) magnet_reg <= hwdata;
            if (wr_restart) restart_reg <= hwdata;
            if (wr_search) search_reg <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer decisions.
    logic [15:0] timer_reg;
    logic [15:0] mon_cnt_reg;
    logic mon_run_reg;
    logic acked_reg;
    logic pf_cause_reg;
    logic armed_reg;
    logic boot_reg;
    logic attempt_active_reg;
    logic [15:0] freq_reg;
    logic dir_reg;
    logic flipped_reg;
    logic [15:0] div_reg;

    wire [4:0] arm_mode = ctrl_reg.auto_restart_mode;
    wire spin_src = ctrl_reg.catch_spin_enable_source ? catch_spin_enable_pin : 1'b1;
    wire fly_ok = ((ctrl_reg.catch_spin_mode == restart_seq_pkg::SPIN_BOTH) ||
                   (ctrl_reg.catch_spin_mode == restart_seq_pkg::SPIN_SETPOINT)) && spin_src;
    wire both_dirs = ctrl_reg.catch_spin_mode == restart_seq_pkg::SPIN_BOTH;
    wire boot_pf = ~boot_reg & supply_lost_strap;
    wire any_fault = fault_in | undervoltage_fault;
    wire running = is_running(state_reg);
    wire fault_evt = ((running | (state_reg == restart_seq_pkg::ST_WAIT)) & any_fault) | boot_pf;
    wire pf_evt = undervoltage_fault | boot_pf;
    wire mon_expire = mon_run_reg & (mon_cnt_reg >= restart_reg.restart_monitor_time);
    wire fail_attempt = fault_evt & attempt_active_reg & (attempts_reg == 8'h0);
    wire fail_set = fail_attempt | mon_expire;
    wire ack_now = (state_reg == restart_seq_pkg::ST_FAULT) & ~acked_reg & ~any_fault &
                   (manual_ack | (ack_allowed(arm_mode, run_command) & ~restart_failed));
    wire auto_go = (state_reg == restart_seq_pkg::ST_FAULT) & acked_reg & ~restart_failed &
                   restart_allowed(arm_mode, pf_cause_reg, run_command);
    wire wait_first = (arm_mode == restart_seq_pkg::ARM_PF) || (arm_mode == restart_seq_pkg::ARM_FAULT) ||
                      (arm_mode == restart_seq_pkg::ARM_ALL);
    wire caught = (dir_reg == motor_dir) & (freq_reg >= motor_speed);
    wire sweep_top = freq_reg == restart_seq_pkg::FREQ_MAX;
    wire search_end = caught | (sweep_top & ~(both_dirs & ~flipped_reg));
    wire step_now = div_reg >= search_reg.search_rate_factor;
    wire [31:0] current_prod = magnetizing_current_ref * search_reg.search_current_level;
    wire entering = state_next != state_reg;
    wire reload = wr_ctrl | (start_success & 1'b1) | (restart_failed & manual_ack & ~run_command);
    wire [7:0] limit_val = (ctrl_reg.start_attempt_limit == 8'h0) ? 8'h1 : ctrl_reg.start_attempt_limit;
    restart_seq_pkg::state_t start_state;

    assign start_state = fly_ok ? restart_seq_pkg::ST_SEARCH : restart_seq_pkg::ST_EXCITE;
    assign status_word = {8'h0, attempts_reg, 5'h0, restart_failed, magnetization_done_flag, ramp_enable,
                          5'h0, state_reg};

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            restart_seq_pkg::ST_OFF: begin
                if (boot_pf) state_next = restart_seq_pkg::ST_FAULT;
                else if (run_command & armed_reg & ~restart_failed) state_next = start_state;
            end
            restart_seq_pkg::ST_WAIT: begin
                if (any_fault | fail_set) state_next = restart_seq_pkg::ST_FAULT;
                else if (!run_command) state_next = restart_seq_pkg::ST_OFF;
                else if (timer_reg >= restart_reg.restart_wait_time) state_next = start_state;
            end
            restart_seq_pkg::ST_SEARCH, restart_seq_pkg::ST_EXCITE,
            restart_seq_pkg::ST_CHECK, restart_seq_pkg::ST_RUN: begin
                if (any_fault | fail_set) begin
                    state_next = restart_seq_pkg::ST_FAULT;
                end else if (!run_command) begin
                    state_next = ctrl_reg.reluctance_motor ? restart_seq_pkg::ST_OFF :
                                 restart_seq_pkg::ST_DEEXC;
                end else if (state_reg == restart_seq_pkg::ST_SEARCH) begin
                    if (search_end) state_next = restart_seq_pkg::ST_EXCITE;
                end else if (state_reg == restart_seq_pkg::ST_EXCITE) begin
                    if (timer_reg >= magnet_reg.excitation_build_time) state_next = restart_seq_pkg::ST_CHECK;
                end else if (state_reg == restart_seq_pkg::ST_CHECK) begin
                    if (timer_reg >= restart_seq_pkg::SUCCESS_TICKS) state_next = restart_seq_pkg::ST_RUN;
                end
            end
            restart_seq_pkg::ST_DEEXC: begin
                if (timer_reg >= magnet_reg.deexcitation_lockout_time) state_next = restart_seq_pkg::ST_OFF;
            end
            restart_seq_pkg::ST_FAULT: begin
                if (auto_go) state_next = wait_first ? restart_seq_pkg::ST_WAIT : start_state;
                else if (acked_reg & ~run_command) state_next = restart_seq_pkg::ST_OFF;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State, step timer and restart bookkeeping.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= restart_seq_pkg::ST_OFF;
            timer_reg <= 16'h0;
            boot_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            boot_reg <= 1'b1;
            if (entering) timer_reg <= 16'h0;
            else if (tick && timer_reg != 16'hffff) timer_reg <= timer_reg + 16'h1;
            if (!run_command) armed_reg <= 1'b1;
            else if (state_reg == restart_seq_pkg::ST_OFF && entering) armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acked_reg <= 1'b0;
            pf_cause_reg <= 1'b0;
            attempts_reg <= 8'h3;
            attempt_active_reg <= 1'b0;
            restart_failed <= 1'b0;
            mon_run_reg <= 1'b0;
            mon_cnt_reg <= 16'h0;
            fault_ack <= 1'b0;
        end else begin
            if (fault_evt) pf_cause_reg <= pf_evt;
            if (entering && state_next == restart_seq_pkg::ST_FAULT) acked_reg <= 1'b0;
            else if (ack_now) acked_reg <= 1'b1;
            fault_ack <= ack_now;
            if (reload) attempts_reg <= limit_val;
            else if (ack_now && counts_attempts(arm_mode) && attempts_reg != 8'h0) attempts_reg <= attempts_reg - 8'h1;
            if (auto_go) attempt_active_reg <= 1'b1;
            else if (start_success || state_reg == restart_seq_pkg::ST_OFF) attempt_active_reg <= 1'b0;
            if (fail_set) restart_failed <= 1'b1;
            else if (manual_ack && !run_command) restart_failed <= 1'b0;
            if (start_success || mon_expire) begin
                mon_run_reg <= 1'b0;
            end else if (fault_evt && !mon_run_reg && counts_attempts(arm_mode) &&
                         restart_reg.restart_monitor_time != 16'h0) begin
                mon_run_reg <= 1'b1;
                mon_cnt_reg <= 16'h0;
            end else if (mon_run_reg && tick && mon_cnt_reg != 16'hffff) begin
                mon_cnt_reg <= mon_cnt_reg + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frequency search and motor outputs.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            freq_reg <= 16'h0;
            dir_reg <= 1'b0;
            flipped_reg <= 1'b0;
            div_reg <= 16'h0;
        end else if (state_reg != restart_seq_pkg::ST_SEARCH && state_next == restart_seq_pkg::ST_SEARCH) begin
            freq_reg <= 16'h0;
            dir_reg <= setpoint_dir;
            flipped_reg <= 1'b0;
            div_reg <= 16'h0;
        end else if (state_reg == restart_seq_pkg::ST_SEARCH) begin
            if (search_end) begin
                if (!caught) freq_reg <= 16'h0;
            end else if (step_now) begin
                div_reg <= 16'h0;
                if (sweep_top) begin
                    freq_reg <= 16'h0;
                    dir_reg <= ~dir_reg;
                    flipped_reg <= 1'b1;
                end else begin
                    freq_reg <= freq_reg + 16'h1;
                end
            end else begin
                div_reg <= div_reg + 16'h1;
            end
        end else if (!is_running(state_reg) && start_state == restart_seq_pkg::ST_EXCITE) begin
            freq_reg <= 16'h0;
            dir_reg <= setpoint_dir;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            motor_on <= 1'b0;
            search_current <= 16'h0;
            out_freq <= 16'h0;
            search_dir <= 1'b0;
            ramp_enable <= 1'b0;
            magnetization_done_flag <= 1'b0;
            start_success <= 1'b0;
        end else begin
            motor_on <= is_running(state_next);
            search_current <= (state_next == restart_seq_pkg::ST_SEARCH) ? current_prod[23:8] : 16'h0;
            out_freq <= freq_reg;
            search_dir <= dir_reg;
            ramp_enable <= (state_next == restart_seq_pkg::ST_CHECK) || (state_next == restart_seq_pkg::ST_RUN);
            magnetization_done_flag <= (state_next == restart_seq_pkg::ST_CHECK) ||
                                       (state_next == restart_seq_pkg::ST_RUN);
            start_success <= (state_reg == restart_seq_pkg::ST_CHECK) && (state_next == restart_seq_pkg::ST_RUN);
        end
    end

    wire unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0], current_prod[31:24], current_prod[7:0]};
endmodule // motor_restart_sequencer
`default_nettype wire

// >>> motor_restart_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module motor_restart_sequencer_assertions (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic motor_on,
    input wire logic fault_in,
    input wire logic undervoltage_fault,
    input wire logic manual_ack,
    input wire logic [15:0] search_current,
    input wire logic ramp_enable,
    input wire logic magnetization_done_flag,
    input wire logic fault_ack,
    input wire logic start_success,
    input wire logic restart_failed
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_flag_with_ramp: assert property (magnetization_done_flag == ramp_enable)
        else $error("done flag differs from ramp enable");
    a_ramp_no_search: assert property (ramp_enable |-> motor_on && search_current == 16'h0)
        else $error("ramp enabled while searching or off");
    a_ramp_after_on: assert property ($rose(ramp_enable) |-> $past(motor_on))
        else $error("ramp enabled before motor on");
    a_success_in_run: assert property (start_success |-> ramp_enable)
        else $error("success without ramp");
    a_success_pulse: assert property (start_success |=> !start_success)
        else $error("success longer than one cycle");
    a_ack_pulse: assert property (fault_ack |=> !fault_ack)
        else $error("ack longer than one cycle");
    a_ack_clear: assert property (fault_ack |-> $past(!fault_in && !undervoltage_fault))
        else $error("ack while fault present");
    a_fault_stops: assert property ((fault_in || undervoltage_fault) && motor_on |-> ##[1:2] !motor_on)
        else $error("motor left on after fault");
    a_failed_held: assert property (restart_failed && !manual_ack |=> restart_failed)
        else $error("restart failure dropped");
    c_success: cover property (start_success);
    c_ack: cover property (fault_ack);
    c_failed: cover property ($rose(restart_failed));
endmodule // motor_restart_sequencer_assertions
bind motor_restart_sequencer motor_restart_sequencer_assertions u_chk (.mclk, .arst_n, .motor_on, .fault_in,
    .undervoltage_fault, .manual_ack, .search_current, .ramp_enable, .magnetization_done_flag, .fault_ack,
    .start_success, .restart_failed);
`default_nettype wire

// >>> motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_model (
    input wire logic mclk,
    input wire logic motor_on,
    input wire logic [15:0] search_current,
    input wire logic [15:0] out_freq,
    input wire logic trip,
    input wire logic [15:0] coast,
    input wire logic coast_dir,
    output var logic [15:0] motor_speed,
    output var logic motor_dir,
    output var logic fault_in
);
    // A single motor, so its coasting speed is the only speed to catch.
    always_ff @(posedge mclk) begin
        motor_speed <= coast;
        motor_dir <= coast_dir;
        // Running more than 16 below the coasting speed without search current trips on overcurrent.
        fault_in <= trip | (motor_on && search_current == 16'h0 && {1'b0, out_freq} + 17'h10 < {1'b0, coast});
    end
endmodule // motor_model
`default_nettype wire

// >>> motor_restart_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motor_restart_sequencer_bench;
    logic mclk, arst_n, hsel, hwrite, hreadyout, run_command, setpoint_dir, motor_dir, fault_in, trip;
    logic undervoltage_fault, manual_ack, motor_on, ramp_enable, fault_ack, start_success, restart_failed;
    logic failed_d, man, spin_pin, search_dir;
    logic [1:0] htrans;
    logic [2:0] ev;
    logic [15:0] motor_speed, mag_ref, search_current, out_freq, coast;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [2:0] notes[$];
    logic [4:0] modes[7] = '{restart_seq_pkg::ARM_ACK, restart_seq_pkg::ARM_PF, restart_seq_pkg::ARM_FAULT,
        restart_seq_pkg::ARM_PF_MAN, restart_seq_pkg::ARM_FAULT_MAN, restart_seq_pkg::ARM_ALL, restart_seq_pkg::ARM_OFF};
    logic [6:0] man_tbl = 7'b1011000;
    int miscompares = 0;
    int num_checks = 0;

    motor_restart_sequencer #(.TICK_CYCLES(10)) dut (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .run_command,
        .catch_spin_enable_pin(spin_pin), .setpoint_dir, .motor_dir, .motor_speed, .magnetizing_current_ref(mag_ref),
        .fault_in, .undervoltage_fault, .manual_ack, .supply_lost_strap(1'b0), .motor_on, .search_current,
        .out_freq, .search_dir, .ramp_enable, .magnetization_done_flag(), .fault_ack, .start_success,
        .restart_failed);
    motor_model u_motor (.mclk, .motor_on, .search_current, .out_freq, .trip, .coast, .coast_dir(setpoint_dir),
        .motor_speed, .motor_dir, .fault_in);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One single AHB transfer; waits on hready in both phases.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic cfg(input logic [4:0] m, input logic [2:0] s);
        bus(1'b1, restart_seq_pkg::CTRL_OFS, {8'h0, 8'h3, 3'h0, m, 3'h0, 1'b0, 1'b1, s});
    endtask

    task automatic pulse(input logic uv);
        @(posedge mclk);
        trip <= !uv;
        undervoltage_fault <= uv;
        @(posedge mclk);
        trip <= 1'b0;
        undervoltage_fault <= 1'b0;
    endtask

    // Waits until only the given number of expected events is still pending.
    task automatic drain(input int left);
        int n;
        n = 0;
        while (notes.size() > left && n < 30000) begin
            @(posedge mclk);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        failed_d <= restart_failed;
        if (fault_ack === 1'b1 || start_success === 1'b1 || (restart_failed === 1'b1 && failed_d !== 1'b1)) begin
            ev = {fault_ack ? 2'h1 : start_success ? 2'h2 : 2'h3, manual_ack};
            if (notes.size() == 0) chk("event", 32'h0, {29'h0, ev});
            else chk("event", {29'h0, notes.pop_front()}, {29'h0, ev});
        end
    end

    initial begin
        #800000;
        miscompares++;
        give_verdict();
    end

    initial begin
        {arst_n, hsel, hwrite, run_command, trip, undervoltage_fault, manual_ack, spin_pin} = '0;
        {htrans, haddr, hwdata, coast} = '0;
        setpoint_dir = 1'b0;
        mag_ref = 16'h0100;
        void'($urandom(38784));
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        mag_ref <= 16'h0100 + 16'($urandom_range(4000));
        repeat (3) @(posedge mclk);
        bus(1'b0, restart_seq_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", restart_seq_pkg::CTRL_RST, q);
        bus(1'b0, restart_seq_pkg::RESTART_OFS, 32'h0);
        chk("restart", restart_seq_pkg::RESTART_RST, q);
        bus(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, restart_seq_pkg::MAGNET_OFS, 32'h5);
        bus(1'b1, restart_seq_pkg::SEARCH_OFS, 32'h0001_0080);
        bus(1'b1, restart_seq_pkg::RESTART_OFS, 32'h3);
        foreach (modes[i]) begin
            cfg(modes[i], (i == 6) ? restart_seq_pkg::SPIN_OFF : restart_seq_pkg::SPIN_BOTH);
            coast <= 16'h40 + 16'($urandom_range(200));
            spin_pin <= i != 0;
            man = man_tbl[i];
            notes.push_back({2'h1, man});
            run_command <= 1'b1;
            repeat (20) @(posedge mclk);
            pulse(1'b0);
            if (man) begin
                repeat (30) @(posedge mclk);
                run_command <= 1'b0;
                manual_ack <= 1'b1;
            end
            drain(0);
            run_command <= 1'b0;
            manual_ack <= 1'b0;
            repeat (20) @(posedge mclk);
        end
        cfg(restart_seq_pkg::ARM_ALL, $urandom_range(1) ? restart_seq_pkg::SPIN_BOTH : restart_seq_pkg::SPIN_SETPOINT);
        coast <= 16'h32 + 16'($urandom_range(250));
        setpoint_dir <= 1'($urandom_range(1));
        notes.push_back({2'h2, 1'b0});
        run_command <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("search_current", (32'(mag_ref) * 32'h80) >> 8, search_current);
        chk("search_dir", setpoint_dir, search_dir);
        drain(0);
        notes.push_back({2'h1, 1'b0});
        notes.push_back({2'h2, 1'b0});
        pulse(1'b0);
        drain(0);
        cfg(restart_seq_pkg::ARM_PF_MAN, restart_seq_pkg::SPIN_SETPOINT);
        notes.push_back({2'h1, 1'b1});
        notes.push_back({2'h2, 1'b0});
        pulse(1'b1);
        repeat (30) @(posedge mclk);
        manual_ack <= 1'b1;
        drain(1);
        manual_ack <= 1'b0;
        drain(0);
        bus(1'b1, restart_seq_pkg::RESTART_OFS, 32'h0014_0032);
        cfg(restart_seq_pkg::ARM_ALL, restart_seq_pkg::SPIN_BOTH);
        notes.push_back({2'h1, 1'b0});
        notes.push_back({2'h3, 1'b0});
        pulse(1'b0);
        drain(0);
        chk("pending", 32'h0, notes.size());
        give_verdict();
    end
endmodule // motor_restart_sequencer_bench
`default_nettype wire
